// File: hdl/fifo_x18_pkg.sv
// shared constants for the 18-bit flagged fifo
package fifo_x18_pkg;
  // data path
  localparam int DATA_W    = 18;
  localparam int OFS_W     = 12;
  localparam int DEPTH_DEF = 4096;
  localparam int DEPTH_MIN = 64;

  // offset register defaults, used until software programs them
  localparam logic [11:0] EMPTY_OFS_RST = 12'h007;
  localparam logic [11:0] FULL_OFS_RST  = 12'h007;

  // offset selector values
  localparam logic OFS_SEL_EMPTY = 1'b0;
  localparam logic OFS_SEL_FULL  = 1'b1;

  // pin bundle layout sent through one synchroniser
  localparam int PIN_WCLK  = 27;
  localparam int PIN_RCLK  = 26;
  localparam int PIN_WEN   = 25;
  localparam int PIN_REN   = 24;
  localparam int PIN_LD    = 23;
  localparam int PIN_FL    = 22;
  localparam int PIN_WXI   = 21;
  localparam int PIN_RXI   = 20;
  localparam int PIN_OE    = 19;
  localparam int PIN_SYNC_FLAG_SELECT = 18;
  localparam int PIN_DATA  = 0;
  localparam int PIN_W     = 28;

  // reset values of the active-low flags
  localparam logic EMPTY_N_RST = 1'b0;
  localparam logic FULL_N_RST  = 1'b1;
  localparam logic AEMPTY_N_RST = 1'b0;
  localparam logic AFULL_N_RST = 1'b1;
  localparam logic HALF_N_RST  = 1'b1;
endpackage

// File: hdl/sync_2ff.sv
`timescale 1ns/1ns
`default_nettype none
// two flip-flop synchroniser; first stage feeds only the second
module sync_2ff #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  // level in and out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] stable_q;

  // constant under reset, no port value loaded
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_q   <= '0;
      stable_q <= '0;
    end else begin
      meta_q   <= din;
      stable_q <= meta_q;
    end
  end

  assign dout = stable_q;
endmodule // sync_2ff
`default_nettype wire

// File: hdl/fifo_x18_flags.sv
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - write clock edge, write enable low, load high, not full: store word, advance.
// - load low with write enable: write clock edges program the offset registers.
// - read clock edge, read enable low, load high, not empty: present word, advance.
// - load low with read enable: read clock edges output the offset registers.
// - empty flag low when no words held, updated only on read clock or retransmit.
// - full flag low at full depth, updated only on write clock.
// - almost-empty from empty offset; asynchronous when strap high, read-clocked when low.
// - almost-full from full offset; asynchronous when strap high, write-clocked when low.
// - output bus driven while output enable low, released while high.
// - reset returns the buffer to empty; user resets after power-up.
// - shared output is half-full standalone, write cascade out when cascaded.
// - standalone: first-load pin pulsed acts as retransmit strobe.
// - read cascade output drives next device's read cascade input.
// - dual-port array of 64 to 4K words of 18 bits, two pointers.
// - successive offset writes alternate empty then full offset, wrapping.
// - retransmit pulse resets read pointer to location zero; read-side flags recomputed.
// - reads while empty ignored; output keeps last valid read.
module fifo_x18_flags
  import fifo_x18_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEF
) (
  // system clock and reset
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  // write port pins
  input  wire logic              write_clk,
  input  wire logic              write_en_n,
  input  wire logic [DATA_W-1:0] data_in,
  // read port pins
  input  wire logic              read_clk,
  input  wire logic              read_en_n,
  input  wire logic              output_en_n,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_out_en,
  // control straps and strobes
  input  wire logic              offset_load_strobe_n,
  input  wire logic              first_load,
  input  wire logic              sync_flag_select,
  input  wire logic              depth_cascade_en,
  // depth expansion chain
  input  wire logic              write_cascade_in,
  input  wire logic              read_cascade_in,
  output logic                   write_cascade_out,
  output logic                   read_cascade_out,
  // status flags
  output logic                   empty_flag_n,
  output logic                   full_flag_n,
  output logic                   almost_empty_flag_n,
  output logic                   almost_full_flag_n
);
  localparam int AW = $clog2(DEPTH);
  localparam int XW = ((AW + 1 > OFS_W) ? AW + 1 : OFS_W) + 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW:0] HALF_CNT = (AW + 1)'(DEPTH / 2);
  localparam logic [XW-1:0] FULL_X = XW'(DEPTH);

  // gray to binary for pointers arriving from the other side
  function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
    logic [AW:0] b;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction

  // every pin passes two flops before use
  logic [PIN_W-1:0] pin_s;
  sync_2ff #(.W(PIN_W)) u_pin_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .din     ({write_clk, read_clk, write_en_n, read_en_n, offset_load_strobe_n,
                first_load, write_cascade_in, read_cascade_in, output_en_n,
                sync_flag_select, data_in}),
    .dout    (pin_s)
  );

  wire              wclk_s  = pin_s[PIN_WCLK];
  wire              rclk_s  = pin_s[PIN_RCLK];
  wire              wen_n_s = pin_s[PIN_WEN];
  wire              ren_n_s = pin_s[PIN_REN];
  wire              ld_n_s  = pin_s[PIN_LD];
  wire              fl_s    = pin_s[PIN_FL];
  wire              wxi_s   = pin_s[PIN_WXI];
  wire              rxi_s   = pin_s[PIN_RXI];
  wire              oe_n_s  = pin_s[PIN_OE];
  wire              sync_flag_select_s = pin_s[PIN_SYNC_FLAG_SELECT];
  wire [DATA_W-1:0] din_s   = pin_s[PIN_DATA +: DATA_W];
  // depth cascade strap is a static level, synchronised once
  logic cascade_s;
  sync_2ff #(.W(1)) u_mode_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .din     (depth_cascade_en),
    .dout    (cascade_s)
  );

  // edge detection on the synchronised pins
  logic wclk_prev_q;
  logic rclk_prev_q;
  logic fl_prev_q;
  logic wxi_prev_q;
  logic rxi_prev_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wclk_prev_q <= 1'b0;
      rclk_prev_q <= 1'b0;
      fl_prev_q   <= 1'b0;
      wxi_prev_q  <= 1'b0;
      rxi_prev_q  <= 1'b0;
    end else begin
      wclk_prev_q <= wclk_s;
      rclk_prev_q <= rclk_s;
      fl_prev_q   <= fl_s;
      wxi_prev_q  <= wxi_s;
      rxi_prev_q  <= rxi_s;
    end
  end

  wire wr_tick = wclk_s & ~wclk_prev_q;
  wire rd_tick = rclk_s & ~rclk_prev_q;
  wire wxi_up  = wxi_s & ~wxi_prev_q;
  wire rxi_up  = rxi_s & ~rxi_prev_q;
  wire retx    = ~cascade_s & fl_s & ~fl_prev_q;

  // state registers
  logic [AW:0]       wptr_q, rptr_q;
  logic [AW:0]       wgray_q, rgray_q;
  logic [AW:0]       wgray_s, rgray_s;
  logic [OFS_W-1:0]  empty_ofs_q, full_ofs_q;
  logic              wsel_q, rsel_q;
  logic              empty_n_q, full_n_q;
  logic              aempty_n_q, afull_n_q, half_n_q;
  logic              wr_token_q, rd_token_q;
  logic [1:0]        init_cnt_q;
  logic              wxo_q, rxo_q, oe_q;
  logic [DATA_W-1:0] data_q;
  logic [DATA_W-1:0] mem [DEPTH];

  // pointers cross as gray codes through two flops each
  sync_2ff #(.W(AW + 1)) u_wptr_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .din     (wgray_q),
    .dout    (wgray_s)
  );
  sync_2ff #(.W(AW + 1)) u_rptr_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .din     (rgray_q),
    .dout    (rgray_s)
  );

  wire [AW:0] rbin_w = gray2bin(rgray_s);
  wire [AW:0] wbin_r = gray2bin(wgray_s);

  // qualified operations
  wire ld_mode  = ~ld_n_s;
  wire do_write = wr_tick & ~wen_n_s & ~ld_mode & full_n_q & wr_token_q;
  wire do_wofs  = wr_tick & ~wen_n_s & ld_mode;
  wire do_read  = rd_tick & ~ren_n_s & ~ld_mode & empty_n_q & rd_token_q;
  wire do_rofs  = rd_tick & ~ren_n_s & ld_mode;

  // next pointers and word counts seen by each side
  wire [AW:0] wptr_d = wptr_q + (AW + 1)'(do_write);
  wire [AW:0] rptr_d = retx ? '0 : rptr_q + (AW + 1)'(do_read);
  wire [AW:0] wcnt   = wptr_q - rbin_w;
  wire [AW:0] wcnt_d = wptr_d - rbin_w;
  wire [AW:0] rcnt   = wbin_r - rptr_q;
  wire [AW:0] rcnt_d = wbin_r - rptr_d;

  // flag decodes; counts may lag by the sync delay, which delays releases, but after a retransmit the write-side count reads low until rptr resyncs
  wire full_d   = (wcnt_d == FULL_CNT);
  wire empty_d  = (rcnt_d == '0);
  wire afull_c  = (XW'(wcnt) + XW'(full_ofs_q)) >= FULL_X;
  wire afull_d  = (XW'(wcnt_d) + XW'(full_ofs_q)) >= FULL_X;
  wire aempty_c = XW'(rcnt) <= XW'(empty_ofs_q);
  wire aempty_d = XW'(rcnt_d) <= XW'(empty_ofs_q);
  wire half_d   = (wcnt_d > HALF_CNT);

  // storage array, no reset on the words
  always_ff @(posedge clk_sys) begin
    if (do_write) begin
      mem[wptr_q[AW-1:0]] <= din_s;
    end
  end

  // write side: pointer, full and half-full flags
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wptr_q   <= '0;
      wgray_q  <= '0;
      full_n_q <= FULL_N_RST;
      half_n_q <= HALF_N_RST;
    end else if (wr_tick) begin
      wptr_q   <= wptr_d;
      wgray_q  <= wptr_d ^ (wptr_d >> 1);
      full_n_q <= ~full_d;
      half_n_q <= ~half_d;
    end
  end

  // read side: pointer and empty flag; retransmit recomputes the read-side flags at once
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rptr_q    <= '0;
      rgray_q   <= '0;
      empty_n_q <= EMPTY_N_RST;
    end else if (rd_tick || retx) begin
      rptr_q    <= rptr_d;
      rgray_q   <= rptr_d ^ (rptr_d >> 1);
      empty_n_q <= ~empty_d;
    end
  end

  // write-clocked almost-full, used in synchronous flag mode
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      afull_n_q <= AFULL_N_RST;
    end else if (wr_tick) begin
      afull_n_q <= ~afull_d;
    end
  end

  // read-clocked almost-empty, used in synchronous flag mode
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      aempty_n_q <= AEMPTY_N_RST;
    end else if (rd_tick || retx) begin
      aempty_n_q <= ~aempty_d;
    end
  end

  // offset registers, written in alternating order
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      empty_ofs_q <= EMPTY_OFS_RST;
      full_ofs_q  <= FULL_OFS_RST;
      wsel_q      <= OFS_SEL_EMPTY;
    end else if (do_wofs) begin
      if (wsel_q == OFS_SEL_EMPTY) begin
        empty_ofs_q <= din_s[OFS_W-1:0];
      end else begin
        full_ofs_q  <= din_s[OFS_W-1:0];
      end
      wsel_q <= ~wsel_q;
    end
  end

  // output register; holds last valid read when empty
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      data_q <= '0;
      rsel_q <= OFS_SEL_EMPTY;
    end else if (do_read) begin
      data_q <= mem[rptr_q[AW-1:0]];
    end else if (do_rofs) begin
      data_q <= DATA_W'((rsel_q == OFS_SEL_EMPTY) ? empty_ofs_q : full_ofs_q);
      rsel_q <= ~rsel_q;
    end
  end

  // output enable follows the pin, registered so the port is a flop
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= ~oe_n_s;
    end
  end

  // cascade tokens: straps read only once their synchronisers hold real levels
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      init_cnt_q <= 2'h0;
      wr_token_q <= 1'b0;
      rd_token_q <= 1'b0;
    end else if (init_cnt_q != 2'h3) begin
      init_cnt_q <= init_cnt_q + 2'h1;
      if (init_cnt_q == 2'h2) begin
        wr_token_q <= ~cascade_s | ~fl_s;
        rd_token_q <= ~cascade_s | ~fl_s;
      end
    end else if (cascade_s) begin
      if (do_write && full_d) begin
        wr_token_q <= 1'b0;
      end else if (wxi_up) begin
        wr_token_q <= 1'b1;
      end
      if (do_read && empty_d) begin
        rd_token_q <= 1'b0;
      end else if (rxi_up) begin
        rd_token_q <= 1'b1;
      end
    end
  end

  // cascade pulses last until the next edge of their own port clock
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wxo_q <= 1'b0;
      rxo_q <= 1'b0;
    end else begin
      if (cascade_s && do_write && full_d) begin
        wxo_q <= 1'b1;
      end else if (wr_tick) begin
        wxo_q <= 1'b0;
      end
      if (cascade_s && do_read && empty_d) begin
        rxo_q <= 1'b1;
      end else if (rd_tick) begin
        rxo_q <= 1'b0;
      end
    end
  end

  // output selection
  assign data_out            = data_q;
  assign data_out_en         = oe_q;
  assign empty_flag_n        = empty_n_q;
  assign full_flag_n         = full_n_q;
  assign almost_empty_flag_n = sync_flag_select_s ? ~aempty_c : aempty_n_q;
  assign almost_full_flag_n  = sync_flag_select_s ? ~afull_c : afull_n_q;
  assign write_cascade_out   = cascade_s ? wxo_q : half_n_q;
  assign read_cascade_out    = rxo_q;
endmodule // fifo_x18_flags
`default_nettype wire

// File: dv/fifo_x18_properties.sv
`timescale 1ns/1ns
`default_nettype none
// pin-level checks of flag and output behaviour
module fifo_x18_checker
  import fifo_x18_pkg::*;
(
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              resetn,
  // pins toward the buffer
  input wire logic              write_clk,
  input wire logic              read_clk,
  input wire logic              output_en_n,
  input wire logic              offset_load_strobe_n,
  input wire logic              first_load,
  input wire logic              sync_flag_select,
  input wire logic              depth_cascade_en,
  // pins from the buffer
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              data_out_en,
  input wire logic              write_cascade_out,
  input wire logic              read_cascade_out,
  input wire logic              empty_flag_n,
  input wire logic              full_flag_n,
  input wire logic              almost_empty_flag_n,
  input wire logic              almost_full_flag_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // pin edges land two or three cycles late through the synchroniser
  sequence write_edge_seen;
    $past(write_clk, 1) || $past(write_clk, 2) || $past(write_clk, 3);
  endsequence
  sequence read_edge_seen;
    $past(read_clk, 1) || $past(read_clk, 2) || $past(first_load, 1) || $past(first_load, 2);
  endsequence
  a_full_own_clock: assert property ($changed(full_flag_n) |-> write_edge_seen)
    else $error("full flag moved without a write clock edge");
  a_empty_own_clock: assert property ($changed(empty_flag_n) |-> read_edge_seen)
    else $error("empty flag moved without a read clock edge");
  a_data_read_cause: assert property ($changed(data_out) |-> read_edge_seen)
    else $error("output word moved without a read clock edge");
  a_oe_drive: assert property ($fell(output_en_n) |-> ##[1:3] data_out_en)
    else $error("output not driven after enable");
  a_oe_release: assert property ($rose(output_en_n) |-> ##[1:3] !data_out_en)
    else $error("output not released after disable");
  a_half_at_full: assert property (!full_flag_n && !depth_cascade_en |-> !write_cascade_out)
    else $error("half flag high while full");
  a_af_at_full: assert property (!full_flag_n && !sync_flag_select |-> !almost_full_flag_n)
    else $error("almost full flag high while full");
  a_ae_at_empty: assert property (!empty_flag_n && !sync_flag_select |-> !almost_empty_flag_n)
    else $error("almost empty flag high while empty");
  a_rxo_standalone: assert property (!depth_cascade_en |-> !read_cascade_out)
    else $error("read cascade out active outside cascade");
  a_hold_empty: assert property (!empty_flag_n && $past(!empty_flag_n) && offset_load_strobe_n
    && $past(offset_load_strobe_n, 4) |-> $stable(data_out))
    else $error("output word changed while empty");
endmodule // fifo_x18_checker

bind fifo_x18_flags fifo_x18_checker fifo_x18_checker_i (
  .clk_sys(clk_sys), .resetn(resetn), .write_clk(write_clk), .read_clk(read_clk),
  .output_en_n(output_en_n), .offset_load_strobe_n(offset_load_strobe_n),
  .first_load(first_load), .sync_flag_select(sync_flag_select),
  .depth_cascade_en(depth_cascade_en), .data_out(data_out), .data_out_en(data_out_en),
  .write_cascade_out(write_cascade_out), .read_cascade_out(read_cascade_out),
  .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
  .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n));
`default_nettype wire

// File: dv/fifo_x18_agent.sv
`timescale 1ns/1ns
`default_nettype none
// writing and reading agent; pin clocks stand still between transfers
module fifo_x18_agent
  import fifo_x18_pkg::*;
(
  // system clock
  input wire logic               clk_sys,
  // write side pins
  output logic                   write_clk,
  output logic                   write_en_n,
  output logic      [DATA_W-1:0] data_in,
  // read side pins
  output logic                   read_clk,
  output logic                   read_en_n,
  output logic                   offset_load_strobe_n
);
  initial begin
    write_clk = 1'b0;
    write_en_n = 1'b1;
    data_in = '0;
    read_clk = 1'b0;
    read_en_n = 1'b1;
    offset_load_strobe_n = 1'b1;
  end
  // levels settle three cycles before the clock rises and stay hold cycles after it falls
  task automatic xfer(input logic rd, input logic en_n, input logic ld_n,
                      input logic [DATA_W-1:0] d, input int hold);
    @(posedge clk_sys);
    offset_load_strobe_n <= ld_n;
    if (rd) read_en_n <= en_n;
    else begin
      write_en_n <= en_n;
      data_in    <= d;
    end
    repeat (3) @(posedge clk_sys);
    if (rd) read_clk <= 1'b1;
    else write_clk <= 1'b1;
    repeat (hold) @(posedge clk_sys);
    read_clk  <= 1'b0;
    write_clk <= 1'b0;
    repeat (hold) @(posedge clk_sys);
    read_en_n            <= 1'b1;
    write_en_n           <= 1'b1;
    offset_load_strobe_n <= 1'b1;
    data_in              <= ~d; // released bus never shows the stale word
  endtask
endmodule // fifo_x18_agent
`default_nettype wire

// File: dv/test_dual_clock_fifo_x18_flags.sv
`timescale 1ns/1ns
`default_nettype none
module test_dual_clock_fifo_x18_flags;
  import fifo_x18_pkg::*;
  localparam int DEPTH = 64;
  logic              clk_sys, resetn, output_en_n, first_load, sync_flag_select;
  logic              write_clk, write_en_n, read_clk, read_en_n, offset_load_strobe_n;
  logic              data_out_en, write_cascade_out, read_cascade_out, cascade_en;
  logic              empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n;
  logic [DATA_W-1:0] data_in, data_out, last_q;
  logic [DATA_W-1:0] hist[$];
  logic [OFS_W-1:0]  ofs[2];
  logic [31:0]       seed;
  logic              wsel, rsel;
  int                error_cnt, n_compared, rd_idx, i;

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // cascade inputs held low in standalone use
  fifo_x18_flags #(.DEPTH(DEPTH)) fifo_x18_flags_i (
    .clk_sys(clk_sys), .resetn(resetn), .write_clk(write_clk), .write_en_n(write_en_n),
    .data_in(data_in), .read_clk(read_clk), .read_en_n(read_en_n),
    .output_en_n(output_en_n), .data_out(data_out), .data_out_en(data_out_en),
    .offset_load_strobe_n(offset_load_strobe_n), .first_load(first_load),
    .sync_flag_select(sync_flag_select), .depth_cascade_en(cascade_en),
    .write_cascade_in(1'b0), .read_cascade_in(1'b0),
    .write_cascade_out(write_cascade_out), .read_cascade_out(read_cascade_out),
    .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n));

  fifo_x18_agent fifo_x18_agent_i (
    .clk_sys(clk_sys), .write_clk(write_clk), .write_en_n(write_en_n), .data_in(data_in),
    .read_clk(read_clk), .read_en_n(read_en_n), .offset_load_strobe_n(offset_load_strobe_n));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int cnt();
    return hist.size() - rd_idx;
  endfunction

  task automatic cmp_word(input string what, input logic [DATA_W-1:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_flag(input string what, input logic exp, got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // model follows the documented defaults after every reset
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    hist.delete();
    rd_idx = 0;
    wsel = 1'b0;
    rsel = 1'b0;
    ofs = '{EMPTY_OFS_RST, FULL_OFS_RST};
    last_q = '0;
  endtask
  // full and half flags only move on write clock edges, almost-full too while sync_flag_select is low
  task automatic push(input logic [DATA_W-1:0] d, input int hold);
    if (cnt() < DEPTH) hist.push_back(d);
    fifo_x18_agent_i.xfer(1'b0, 1'b0, 1'b1, d, hold);
    cmp_flag("full", cnt() != DEPTH, full_flag_n);
    cmp_flag("half", cnt() <= DEPTH / 2, write_cascade_out);
    cmp_flag("almost full", cnt() < DEPTH - int'(ofs[1]), almost_full_flag_n);
  endtask
  task automatic pop(input int hold);
    if (cnt() > 0) last_q = hist[rd_idx++];
    fifo_x18_agent_i.xfer(1'b1, 1'b0, 1'b1, '0, hold);
    cmp_word("read word", last_q, data_out);
    cmp_flag("empty", cnt() != 0, empty_flag_n);
    cmp_flag("almost empty", cnt() > int'(ofs[0]), almost_empty_flag_n);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys);
    error_cnt++;
    give_verdict();
  end

  initial begin
    resetn = 1'b0;
    output_en_n = 1'b0;
    first_load = 1'b0;
    cascade_en = 1'b0;
    sync_flag_select = 1'b0;
    seed = 32'hf43db580;
    error_cnt = 0;
    n_compared = 0;
    do_reset();
    cmp_flag("reset empty", 1'b0, empty_flag_n);
    cmp_flag("reset full", 1'b1, full_flag_n);
    cmp_word("reset word", '0, data_out);
    $display("test reset done");
    // one word past full is refused
    for (i = 0; i <= DEPTH; i++) begin
      seed = lfsr(seed);
      push(seed[DATA_W-1:0], 4 + i % 3);
    end
    $display("test fill done");
    fifo_x18_agent_i.xfer(1'b1, 1'b1, 1'b1, '0, 4);
    for (i = 0; i <= DEPTH; i++) pop(4 + i % 2);
    $display("test drain done");
    // upper bits of the offset word are dropped, three writes wrap to empty
    for (i = 0; i < 3; i++) begin
      ofs[wsel] = (i == 1) ? 12'h005 : 12'h002;
      fifo_x18_agent_i.xfer(1'b0, 1'b0, 1'b0, {6'h3f, ofs[wsel]}, 4);
      wsel = ~wsel;
    end
    for (i = 0; i < 3; i++) begin
      fifo_x18_agent_i.xfer(1'b1, 1'b0, 1'b0, '0, 4);
      cmp_word("offset read", {6'h00, ofs[rsel]}, data_out);
      rsel = ~rsel;
    end
    last_q = data_out;
    // asynchronous almost flags from here on, no read tick needed to move them
    sync_flag_select <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cmp_flag("async almost empty", 1'b0, almost_empty_flag_n);
    for (i = 0; i < 4; i++) push(18'h00a00 + 18'(i), 4);
    cmp_flag("async almost empty", 1'b1, almost_empty_flag_n);
    fifo_x18_agent_i.xfer(1'b1, 1'b1, 1'b1, '0, 4);
    for (i = 0; i < 4; i++) pop(4);
    $display("test offsets done");
    output_en_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cmp_flag("bus driven", 1'b0, data_out_en);
    output_en_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    cmp_flag("bus driven", 1'b1, data_out_en);
    $display("test output enable done");
    // second reset in mid-run, then replay from the first location
    do_reset();
    for (i = 0; i < 3; i++) push(18'h2c000 + 18'(i), 4);
    fifo_x18_agent_i.xfer(1'b1, 1'b1, 1'b1, '0, 4);
    pop(4);
    pop(4);
    first_load <= 1'b1;
    repeat (4) @(posedge clk_sys);
    first_load <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd_idx = 0;
    cmp_flag("empty after replay", 1'b1, empty_flag_n);
    for (i = 0; i < 3; i++) pop(4);
    $display("test retransmit done");
    // later device of a depth chain holds no token, so its write is ignored
    cascade_en <= 1'b1;
    first_load <= 1'b1;
    do_reset();
    fifo_x18_agent_i.xfer(1'b0, 1'b0, 1'b1, 18'h01234, 4);
    fifo_x18_agent_i.xfer(1'b1, 1'b1, 1'b1, '0, 4);
    cmp_flag("cascade empty", 1'b0, empty_flag_n);
    cmp_flag("cascade out", 1'b0, write_cascade_out);
    $display("test cascade done");
    give_verdict();
  end
endmodule // test_dual_clock_fifo_x18_flags
`default_nettype wire
